/* File: verilog/see_defs.svh */
// Shared constants for the serial EEPROM write path and its bus master.
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH
// System clock rate in MHz.
`define SEE_CLK_MHZ 250
// Typical and worst-case internal write cycle in microseconds.
`define SEE_TWC_TYP_US 3000
`define SEE_TWC_MAX_US 5000
// Serial clock rate made by the master, in kHz.
`define SEE_SCL_KHZ 400
// System cycles per quarter of a serial bit.
`define SEE_QTR_CYC ((`SEE_CLK_MHZ * 1000) / (`SEE_SCL_KHZ * 4))
// Slave address of the memory (plain default, any value works).
`define SEE_DEV_ADDR 7'h50
// Page size, word-address bytes and array address width.
`define SEE_PAGE_BYTES 128
`define SEE_ADDR_BYTES 2
`define SEE_MEM_AW 10
// Bit index of the acknowledge slot within a nine-bit frame.
`define SEE_ACK_BIT 4'h8
// Direction bit value of a write command.
`define SEE_RW_WRITE 1'b0
// Quarter indices inside one serial bit.
`define SEE_Q_SET 2'h0
`define SEE_Q_RISE 2'h1
`define SEE_Q_MID 2'h2
`define SEE_Q_FALL 2'h3
`endif

/* File: verilog/see_pkg.sv */
// Types shared by the memory end and the master end.
package see_pkg;
    // Memory end protocol states.
    typedef enum logic [2:0] {
        SD_IDLE = 3'b000, SD_CTRL = 3'b001, SD_ADDR = 3'b010, SD_DATA = 3'b011, SD_IGNORE = 3'b100
    } see_dst_e;
    // Master sequence states.
    typedef enum logic [3:0] {
        SM_IDLE = 4'b0000, SM_START = 4'b0001, SM_CTRL = 4'b0010, SM_ADDR = 4'b0011,
        SM_LOAD = 4'b0100, SM_DATA = 4'b0101, SM_STOP = 4'b0110, SM_PSTART = 4'b0111,
        SM_PCTRL = 4'b1000, SM_PSTOP = 4'b1001, SM_RS1 = 4'b1010, SM_RONES = 4'b1011,
        SM_RS2 = 4'b1100, SM_RSTOP = 4'b1101
    } see_mst_e;
    // Kind of bus symbol a master state sends.
    typedef enum logic [1:0] {
        SY_START = 2'b00, SY_STOP = 2'b01, SY_BYTE = 2'b10, SY_ONES = 2'b11
    } see_sym_e;
endpackage : see_pkg

/* File: verilog/see_if.sv */
// Two-wire link between the master end and the memory end.
`timescale 1ns/10ps
`default_nettype none
interface see_if;
    // Master pin drives; output value is always low, enable pulls the wire.
    logic mst_scl_o;
    logic mst_scl_oe;
    logic mst_sda_o;
    logic mst_sda_oe;
    // Memory pin drive on the data wire.
    logic dev_sda_o;
    logic dev_sda_oe;
    // Resolved wire levels with pull-ups.
    logic scl;
    logic sda;

    // Open-drain resolution: any enabled low driver wins.
    assign scl = ~(mst_scl_oe & ~mst_scl_o);
    assign sda = ~((mst_sda_oe & ~mst_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport mst (
        output mst_scl_o, mst_scl_oe, mst_sda_o, mst_sda_oe,
        input scl, sda
    );
    modport dev (
        output dev_sda_o, dev_sda_oe,
        input scl, sda
    );
endinterface : see_if
`default_nettype wire

/* File: verilog/see_eeprom_dev.sv */
// Memory end: two-wire write path with page buffer and self-timed programming.
`timescale 1ns/10ps
`default_nettype none
`include "see_defs.svh"
module see_eeprom_dev #(
    parameter int PAGE_BYTES = `SEE_PAGE_BYTES,
    parameter int ADDR_BYTES = `SEE_ADDR_BYTES,
    parameter int MEM_AW = `SEE_MEM_AW,
    parameter logic [6:0] DEV_ADDR = `SEE_DEV_ADDR,
    parameter int unsigned WR_CYC = `SEE_TWC_TYP_US * `SEE_CLK_MHZ
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Two-wire link.
    see_if.dev bus,
    // Array read port for the user.
    input wire logic [MEM_AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    // Programming in progress.
    output logic busy
);
    localparam int COLW = $clog2(PAGE_BYTES);
    localparam int ROWW = MEM_AW - COLW;

    logic scl_s1_q, scl_s2_q, scl_p_q;
    logic sda_s1_q, sda_s2_q, sda_p_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    see_pkg::see_dst_e state_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shift_q;
    logic ack_oe_q;
    logic [1:0] abyte_q;
    logic [15:0] addr_q;
    logic [15:0] addr_nx;
    logic [ROWW-1:0] row_q;
    logic [COLW-1:0] col_q;
    logic byte_end, ctrl_ok, busy_now;
    logic [7:0] f_data_q [2];
    logic [COLW-1:0] f_col_q [2];
    logic [1:0] f_cnt_q;
    logic f_wp_q, f_rp_q;
    logic f_full, f_empty, push, pop;
    logic [7:0] pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pvalid_q;
    logic prog_pend_q, prog_q, prog_end, prog_wr;
    logic [COLW:0] pidx_q;
    logic [31:0] timer_q;
    logic [7:0] mem_q [2**MEM_AW];
    logic busy_q;

    // Pins pass two flip-flops; a third stage holds the previous level.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s1_q <= bus.scl;
            scl_s2_q <= scl_s1_q;
            scl_p_q <= scl_s2_q;
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
            sda_p_q <= sda_s2_q;
        end
    end

    // Clock edges and framing conditions seen on the link.
    assign scl_rise = scl_s2_q & ~scl_p_q;
    assign scl_fall = ~scl_s2_q & scl_p_q;
    assign start_cond = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    assign stop_cond = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

    // Byte completion, address assembly and control byte check.
    assign byte_end = scl_fall & (bitcnt_q == `SEE_ACK_BIT);
    assign addr_nx = {addr_q[7:0], shift_q};
    assign busy_now = prog_pend_q | prog_q;
    assign ctrl_ok = (shift_q[7:1] == DEV_ADDR) & (shift_q[0] == `SEE_RW_WRITE) & ~busy_now;
    assign push = byte_end & (state_q == see_pkg::SD_DATA) & ~f_full;

    // The memory only ever pulls the data wire low.
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = ack_oe_q;

    // Protocol state: bit counting, acknowledge and pointers.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= see_pkg::SD_IDLE;
            bitcnt_q <= 4'h0;
            shift_q <= 8'h00;
            ack_oe_q <= 1'b0;
            abyte_q <= 2'h0;
            addr_q <= 16'h0000;
            row_q <= '0;
            col_q <= '0;
        end else if (start_cond) begin
            // A start anywhere restarts the frame, even mid-byte.
            state_q <= see_pkg::SD_CTRL;
            bitcnt_q <= 4'h0;
            ack_oe_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= see_pkg::SD_IDLE;
            ack_oe_q <= 1'b0;
        end else begin
            if (scl_rise && state_q != see_pkg::SD_IDLE) begin
                if (bitcnt_q == `SEE_ACK_BIT) begin
                    bitcnt_q <= 4'h0;
                end else begin
                    shift_q <= {shift_q[6:0], sda_s2_q};
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
            end
            if (scl_fall) begin
                ack_oe_q <= 1'b0;
                if (bitcnt_q == `SEE_ACK_BIT) begin
                    case (state_q)
                        see_pkg::SD_CTRL: begin
                            if (ctrl_ok) begin
                                ack_oe_q <= 1'b1;
                                state_q <= see_pkg::SD_ADDR;
                                abyte_q <= 2'h0;
                            end else begin
                                state_q <= see_pkg::SD_IGNORE;
                            end
                        end
                        see_pkg::SD_ADDR: begin
                            ack_oe_q <= 1'b1;
                            addr_q <= addr_nx;
                            if (abyte_q == 2'(ADDR_BYTES - 1)) begin
                                // Upper bits pick the page, lower bits the byte in it.
                                row_q <= addr_nx[MEM_AW-1:COLW];
                                col_q <= addr_nx[COLW-1:0];
                                state_q <= see_pkg::SD_DATA;
                            end else begin
                                abyte_q <= abyte_q + 2'h1;
                            end
                        end
                        see_pkg::SD_DATA: begin
                            // A full buffer withholds the acknowledge so no byte is lost silently.
                            if (!f_full) begin
                                ack_oe_q <= 1'b1;
                                col_q <= col_q + 1'b1;
                            end
                        end
                        default: begin
                            ack_oe_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Two-entry buffer between the link and the page buffer.
    assign f_full = (f_cnt_q == 2'h2);
    assign f_empty = (f_cnt_q == 2'h0);
    assign pop = ~f_empty & ~prog_q;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            f_cnt_q <= 2'h0;
            f_wp_q <= 1'b0;
            f_rp_q <= 1'b0;
        end else begin
            if (push) begin
                f_data_q[f_wp_q] <= shift_q;
                f_col_q[f_wp_q] <= col_q;
                f_wp_q <= ~f_wp_q;
            end
            if (pop) begin
                f_rp_q <= ~f_rp_q;
            end
            f_cnt_q <= f_cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Page buffer: later bytes to the same column overwrite earlier ones.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pvalid_q <= '0;
        end else if (prog_end) begin
            pvalid_q <= '0;
        end else if (pop) begin
            pbuf_q[f_col_q[f_rp_q]] <= f_data_q[f_rp_q];
            pvalid_q[f_col_q[f_rp_q]] <= 1'b1;
        end
    end

    // Self-timed programming; it waits for the buffer to drain first.
    assign prog_end = prog_q & (timer_q == WR_CYC - 1);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prog_pend_q <= 1'b0;
            prog_q <= 1'b0;
            pidx_q <= '0;
            timer_q <= 32'h0000_0000;
        end else begin
            if (stop_cond && state_q == see_pkg::SD_DATA && ((|pvalid_q) || !f_empty)) begin
                prog_pend_q <= 1'b1;
            end
            if (prog_pend_q && f_empty) begin
                prog_pend_q <= 1'b0;
                prog_q <= 1'b1;
                pidx_q <= '0;
                timer_q <= 32'h0000_0000;
            end
            if (prog_q) begin
                if (!pidx_q[COLW]) begin
                    pidx_q <= pidx_q + 1'b1;
                end
                timer_q <= timer_q + 32'h0000_0001;
                if (prog_end) begin
                    prog_q <= 1'b0;
                end
            end
        end
    end

    // Array writes walk the whole page once, one column per clock; reads are registered.
    assign prog_wr = prog_q & ~pidx_q[COLW] & pvalid_q[pidx_q[COLW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (prog_wr) begin
            mem_q[{row_q, pidx_q[COLW-1:0]}] <= pbuf_q[pidx_q[COLW-1:0]];
        end
        rd_data <= mem_q[rd_addr];
    end

    // Busy flag to the user.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_now;
        end
    end
    assign busy = busy_q;
endmodule : see_eeprom_dev
`default_nettype wire

/* File: verilog/see_i2c_mst.sv */
// Master end: page writes, acknowledge polling and bus recovery.
`timescale 1ns/10ps
`default_nettype none
`include "see_defs.svh"
module see_i2c_mst #(
    parameter int QTR_CYC = `SEE_QTR_CYC,
    parameter int ADDR_BYTES = `SEE_ADDR_BYTES,
    parameter logic [6:0] DEV_ADDR = `SEE_DEV_ADDR
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Two-wire link.
    see_if.mst bus,
    // Write stream; the address rides with the first byte.
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_last,
    input wire logic [15:0] wr_addr,
    // Status.
    output logic done,
    output logic err,
    output logic busy
);
    see_pkg::see_mst_e state_q;
    logic [15:0] qdiv_q;
    logic tick;
    logic [1:0] qcnt_q;
    logic [3:0] bcnt_q;
    logic [7:0] tx_q;
    logic [15:0] addr_q;
    logic [1:0] ab_q;
    logic last_q, ack_q, scl_lvl_q, sda_lvl_q;
    logic sda_s1_q, sda_s2_q;
    logic done_q, err_q;
    see_pkg::see_sym_e sym;

    // Symbol kind sent by each state.
    function automatic see_pkg::see_sym_e sym_of(input see_pkg::see_mst_e s);
        case (s)
            see_pkg::SM_START, see_pkg::SM_PSTART, see_pkg::SM_RS1, see_pkg::SM_RS2: sym_of = see_pkg::SY_START;
            see_pkg::SM_STOP, see_pkg::SM_PSTOP, see_pkg::SM_RSTOP: sym_of = see_pkg::SY_STOP;
            see_pkg::SM_RONES: sym_of = see_pkg::SY_ONES;
            default: sym_of = see_pkg::SY_BYTE;
        endcase
    endfunction : sym_of

    assign sym = sym_of(state_q);
    assign wr_ready = (state_q == see_pkg::SM_LOAD);
    assign busy = (state_q != see_pkg::SM_IDLE);
    assign done = done_q;
    assign err = err_q;
    assign bus.mst_scl_o = 1'b0;
    assign bus.mst_sda_o = 1'b0;
    assign bus.mst_scl_oe = ~scl_lvl_q;
    assign bus.mst_sda_oe = ~sda_lvl_q;

    // Quarter-bit enable from the system clock.
    assign tick = (qdiv_q == 16'(QTR_CYC - 1));
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            qdiv_q <= 16'h0000;
        end else if (tick) begin
            qdiv_q <= 16'h0000;
        end else begin
            qdiv_q <= qdiv_q + 16'h0001;
        end
    end

    // Data wire passes two flip-flops before the acknowledge sample.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // Sequencer: each bit is four quarters, set, rise, middle, fall.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= see_pkg::SM_IDLE;
            qcnt_q <= `SEE_Q_SET;
            bcnt_q <= 4'h0;
            tx_q <= 8'h00;
            addr_q <= 16'h0000;
            ab_q <= 2'h0;
            last_q <= 1'b0;
            ack_q <= 1'b0;
            scl_lvl_q <= 1'b1;
            sda_lvl_q <= 1'b1;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            if (state_q == see_pkg::SM_IDLE) begin
                if (wr_valid) begin
                    addr_q <= wr_addr;
                    state_q <= see_pkg::SM_START;
                end
            end else if (state_q == see_pkg::SM_LOAD) begin
                if (wr_valid) begin
                    tx_q <= wr_data;
                    last_q <= wr_last;
                    state_q <= see_pkg::SM_DATA;
                end
            end else if (tick) begin
                qcnt_q <= qcnt_q + 2'h1;
                case (qcnt_q)
                    `SEE_Q_SET: begin
                        if (sym == see_pkg::SY_STOP) begin
                            sda_lvl_q <= 1'b0;
                        end else if (sym == see_pkg::SY_BYTE) begin
                            sda_lvl_q <= (bcnt_q == `SEE_ACK_BIT) | tx_q[7];
                        end else begin
                            sda_lvl_q <= 1'b1;
                        end
                    end
                    `SEE_Q_RISE: begin
                        scl_lvl_q <= 1'b1;
                    end
                    `SEE_Q_MID: begin
                        if (sym == see_pkg::SY_START) begin
                            sda_lvl_q <= 1'b0;
                        end else if (sym == see_pkg::SY_STOP) begin
                            sda_lvl_q <= 1'b1;
                        end else if (bcnt_q == `SEE_ACK_BIT) begin
                            ack_q <= ~sda_s2_q;
                        end
                    end
                    default: begin
                        scl_lvl_q <= (sym == see_pkg::SY_STOP);
                        if ((sym == see_pkg::SY_BYTE || sym == see_pkg::SY_ONES) && bcnt_q != `SEE_ACK_BIT) begin
                            bcnt_q <= bcnt_q + 4'h1;
                            tx_q <= {tx_q[6:0], 1'b0};
                        end else begin
                            bcnt_q <= 4'h0;
                            case (state_q)
                                see_pkg::SM_START, see_pkg::SM_PSTART: begin
                                    tx_q <= {DEV_ADDR, `SEE_RW_WRITE};
                                    state_q <= (state_q == see_pkg::SM_START) ? see_pkg::SM_CTRL : see_pkg::SM_PCTRL;
                                end
                                see_pkg::SM_CTRL: begin
                                    tx_q <= (ADDR_BYTES == 2) ? addr_q[15:8] : addr_q[7:0];
                                    ab_q <= 2'h0;
                                    state_q <= ack_q ? see_pkg::SM_ADDR : see_pkg::SM_RS1;
                                    err_q <= ~ack_q;
                                end
                                see_pkg::SM_ADDR: begin
                                    tx_q <= addr_q[7:0];
                                    ab_q <= ab_q + 2'h1;
                                    err_q <= ~ack_q;
                                    if (!ack_q) begin
                                        state_q <= see_pkg::SM_RS1;
                                    end else if (ab_q == 2'(ADDR_BYTES - 1)) begin
                                        state_q <= see_pkg::SM_LOAD;
                                    end
                                end
                                see_pkg::SM_DATA: begin
                                    err_q <= ~ack_q;
                                    if (!ack_q) begin
                                        state_q <= see_pkg::SM_RS1;
                                    end else begin
                                        state_q <= last_q ? see_pkg::SM_STOP : see_pkg::SM_LOAD;
                                    end
                                end
                                see_pkg::SM_STOP: begin
                                    state_q <= see_pkg::SM_PSTART;
                                end
                                see_pkg::SM_PCTRL: begin
                                    state_q <= ack_q ? see_pkg::SM_PSTOP : see_pkg::SM_PSTART;
                                end
                                see_pkg::SM_PSTOP: begin
                                    done_q <= 1'b1;
                                    state_q <= see_pkg::SM_IDLE;
                                end
                                see_pkg::SM_RS1: begin
                                    state_q <= see_pkg::SM_RONES;
                                end
                                see_pkg::SM_RONES: begin
                                    state_q <= see_pkg::SM_RS2;
                                end
                                see_pkg::SM_RS2: begin
                                    state_q <= see_pkg::SM_RSTOP;
                                end
                                default: begin
                                    state_q <= see_pkg::SM_IDLE;
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
    end
endmodule : see_i2c_mst
`default_nettype wire

/* File: testbench/see_write_ack_poll_props.sv */
// Checker for the two-wire link between the master end and the memory end.
`timescale 1ns/10ps
`default_nettype none
module see_write_ack_poll_props (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Pin drives and resolved wires.
    input wire logic mst_scl_o,
    input wire logic mst_scl_oe,
    input wire logic mst_sda_o,
    input wire logic mst_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    // Bit timing below assumes quarters of four system cycles, as the bench runs.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_drive_low_only: assert property (!mst_scl_o && !mst_sda_o && !dev_sda_o)
        else $error("open-drain output value not low");
    a_wire_levels: assert property (scl == !mst_scl_oe && sda == !(mst_sda_oe || dev_sda_oe))
        else $error("wire level does not follow the drivers");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !mst_scl_oe && !mst_sda_oe && !dev_sda_oe)
        else $error("a driver is active after a reset edge");
    a_ack_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("acknowledge raised while the clock is high");
    a_ack_one_bit: assert property ($rose(dev_sda_oe) |=> dev_sda_oe[*8] ##[5:9] !dev_sda_oe)
        else $error("acknowledge not held for exactly one bit");
    a_dev_still_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("memory moved the data wire while the clock was high");
    a_scl_high_time: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase shorter than two quarters");
    a_scl_low_time: assert property ($fell(scl) |-> !scl[*8])
        else $error("clock low phase shorter than two quarters");
    a_stop_dev_free: assert property (scl && $rose(sda) |-> !dev_sda_oe)
        else $error("memory drives the data wire at a stop");
    // Main link events.
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
endmodule : see_write_ack_poll_props
`default_nettype wire

/* File: testbench/see_write_ack_poll_tb.sv */
// Bench for the master end writing pages into the memory end over the link.
`timescale 1ns/10ps
`default_nettype none
module see_write_ack_poll_tb;
    localparam int PB = 8;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_valid = 1'b0;
    logic wr_valid2 = 1'b0;
    logic wr_last = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [15:0] wr_addr = 16'h0000;
    logic [9:0] rd_addr = 10'h000;
    logic [7:0] rd_data;
    logic wr_ready, done, err, busy_m, busy_d, err2, busy_m2, busy_d2;
    logic seen_busy = 1'b0;
    logic seen_err = 1'b0;
    int fails = 0;
    int n_checks = 0;
    // Watched status outputs, picked by index in wait_for.
    logic [3:0] mon;
    assign mon = {busy_m2, err2, done, wr_ready};
    see_if link();
    see_if link_bad();
    // Matching pair with short quarters, short programming and eight-byte pages.
    see_i2c_mst #(.QTR_CYC(4)) see_i2c_mst_i (.sys_clk(sys_clk), .rstn(rstn), .bus(link.mst), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last), .wr_addr(wr_addr), .done(done), .err(err),
        .busy(busy_m));
    see_eeprom_dev #(.PAGE_BYTES(PB), .WR_CYC(200)) see_eeprom_dev_i (.sys_clk(sys_clk), .rstn(rstn),
        .bus(link.dev), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy_d));
    // Second pair: the master calls an address that the memory does not answer.
    see_i2c_mst #(.QTR_CYC(4), .DEV_ADDR(7'h51)) see_i2c_mst_i2 (.sys_clk(sys_clk), .rstn(rstn), .bus(link_bad.mst),
        .wr_valid(wr_valid2), .wr_ready(), .wr_data(wr_data), .wr_last(wr_last), .wr_addr(wr_addr), .done(),
        .err(err2), .busy(busy_m2));
    see_eeprom_dev #(.PAGE_BYTES(PB), .WR_CYC(200)) see_eeprom_dev_i2 (.sys_clk(sys_clk), .rstn(rstn),
        .bus(link_bad.dev), .rd_addr(rd_addr), .rd_data(), .busy(busy_d2));
    see_write_ack_poll_props see_write_ack_poll_props_i (.sys_clk(sys_clk), .rstn(rstn),
        .mst_scl_o(link.mst_scl_o), .mst_scl_oe(link.mst_scl_oe), .mst_sda_o(link.mst_sda_o),
        .mst_sda_oe(link.mst_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));
    // System clock of 4 ns.
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Remembers that the memory reported programming and that the good master raised its error flag.
    always @(posedge sys_clk) begin
        if (busy_d === 1'b1) seen_busy <= 1'b1;
        if (err === 1'b1) seen_err <= 1'b1;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Waits, bounded, until a watched output shows a level at a falling clock edge.
    task automatic wait_for(input int sel, input logic v, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (mon[sel] !== v && k < lim);
    endtask : wait_for
    // Streams n bytes from d0 upwards to address a, then waits for the polled finish.
    task automatic wr_page(input logic [15:0] a, input int n, input logic [7:0] d0);
        for (int i = 0; i < n; i++) begin
            wr_addr <= a;
            wr_data <= d0 + 8'(i);
            wr_last <= (i == n - 1);
            wr_valid <= 1'b1;
            wait_for(0, 1'b1, 5000);
            @(posedge sys_clk);
        end
        wr_valid <= 1'b0;
        wait_for(1, 1'b1, 8000);
        chk({7'h00, done}, 8'h01);
        chk({7'h00, busy_m}, 8'h00);
        chk({7'h00, busy_d}, 8'h00);
        @(posedge sys_clk);
    endtask : wr_page
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(rd_data, exp);
        @(posedge sys_clk);
    endtask : rd_chk
    // Main sequence.
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        wr_page(16'h0100, 1, 8'hA5);
        chk({7'h00, seen_busy}, 8'h01);
        rd_chk(10'h100, 8'hA5);
        wr_page(16'h00FE, PB + 2, 8'h10);
        // Byte i lands in column (6 + i) mod PB; the last two overwrite columns 6 and 7.
        for (int c = 0; c < PB; c++) begin
            rd_chk(10'h0F8 + 10'(c), 8'h10 + 8'((c + PB - 6) % PB) + ((c + PB - 6) % PB < 2 ? 8'h08 : 8'h00));
        end
        rd_chk(10'h100, 8'hA5);
        wr_valid2 <= 1'b1;
        @(posedge sys_clk);
        wr_valid2 <= 1'b0;
        wait_for(2, 1'b1, 3000);
        chk({7'h00, err2}, 8'h01);
        wait_for(3, 1'b0, 3000);
        chk({7'h00, busy_m2}, 8'h00);
        chk({7'h00, busy_d2}, 8'h00);
        chk({7'h00, seen_err}, 8'h00);
        complete_run();
    end
    // Watchdog well beyond the expected run of some 3600 cycles.
    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        complete_run();
    end
endmodule : see_write_ack_poll_tb
`default_nettype wire
